//--- sim/ppmc_partner.sv
// print engine and mark sensor model facing the panel block
// assumes the block's clock and active-low reset; reacts to its levels
`timescale 1ns/1ps
module ppmc_partner #(
	parameter int REPORT_LEN = 20,
	parameter int MARK_GAP = 15
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic motor_i,
	input wire logic report_i,
	input wire logic sample_i,
	output logic done_o,
	output logic busy_o,
	output logic mark_o
);
	logic [7:0] rcnt;
	logic [7:0] mcnt;
	logic [2:0] bcnt;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rcnt <= 8'h00;
			mcnt <= 8'h00;
			bcnt <= 3'h0;
			done_o <= 1'b0;
			busy_o <= 1'b0;
			mark_o <= 1'b0;
		end else begin
			// report ends once, a fixed time after it starts
			rcnt <= report_i ? rcnt + 8'h01 : 8'h00;
			done_o <= report_i && (rcnt == 8'(REPORT_LEN - 1));
			// engine runs on after sample stops, so a premature cut is visible
			bcnt <= sample_i ? 3'h5 : ((bcnt != 3'h0) ? bcnt - 3'h1 : 3'h0);
			busy_o <= sample_i || (bcnt != 3'h0);
			// moving paper brings the next mark a fixed distance on
			mcnt <= motor_i ? mcnt + 8'h01 : 8'h00;
			mark_o <= motor_i && (mcnt >= 8'(MARK_GAP));
		end
	end
endmodule

//--- sim/ppmc_top_bench.sv
// self-checking bench for the front-panel mode control block
// assumes an AXI4-Lite master here and the engine model beside the block
`timescale 1ns/1ps
module ppmc_top_bench
	import ppmc_pkg::*;
;
	localparam int STARTUP = 32;
	logic clk, rst_n, feed_n, setup_n, paper_end, head_open, power_good, error_in;
	logic done, busy, mark, motor, report, sample, cut, yes, no, hex, l_pwr, l_pe, l_err, irq;
	ppmc_axi_req_t req;
	ppmc_axi_rsp_t rsp;
	int n_errors, checked, cut_n, yes_n, no_n, y0, n0;
	logic [31:0] r;
	logic [33:0] exp_q[$];

	ppmc_top #(.DEBOUNCE_LEN(8), .STARTUP_LEN(STARTUP)) dut_u (.clock_i(clk), .rst_n_i(rst_n),
		.feed_button_n_i(feed_n), .setup_button_n_i(setup_n), .paper_end_i(paper_end),
		.head_open_i(head_open), .mark_detect_i(mark), .power_good_i(power_good),
		.error_i(error_in), .report_done_i(done), .engine_busy_i(busy), .axi_i(req), .axi_o(rsp),
		.feed_motor_o(motor), .print_report_o(report), .print_sample_o(sample), .cut_o(cut),
		.cfg_yes_o(yes), .cfg_no_o(no), .hex_dump_o(hex), .lamp_power_o(l_pwr),
		.lamp_paper_out_o(l_pe), .lamp_error_o(l_err), .irq_o(irq));
	ppmc_partner partner_u (.clock_i(clk), .rst_n_i(rst_n), .motor_i(motor), .report_i(report),
		.sample_i(sample), .done_o(done), .busy_o(busy), .mark_o(mark));

	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task chb(input logic seen, input logic exp);
		chk({33'h0, seen}, {33'h0, exp});
	endtask
	task finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task btn(input logic f, input logic s, input int n);
		@(posedge clk);
		feed_n <= ~f;
		setup_n <= ~s;
		w(n);
	endtask
	task boot(input logic f, input logic s);
		@(posedge clk);
		rst_n <= 1'b0;
		feed_n <= ~f;
		setup_n <= ~s;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		w(STARTUP + 4);
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] resp);
		@(posedge clk);
		exp_q.push_back({resp, 32'h0});
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [33:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
	endtask

	// monitor: every bus answer is matched against the oldest note
	always @(posedge clk) begin
		if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready)) begin
			if (exp_q.size() == 0)
				n_errors++;
			else
				chk(rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0}, exp_q.pop_front());
		end
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			cut_n <= 0;
			yes_n <= 0;
			no_n <= 0;
		end else begin
			cut_n <= cut_n + int'(cut);
			yes_n <= yes_n + int'(yes);
			no_n <= no_n + int'(no);
		end
	end
	initial begin
		repeat (12000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		feed_n = 1'b1;
		setup_n = 1'b1;
		paper_end = 1'b0;
		head_open = 1'b0;
		power_good = 1'b1;
		error_in = 1'b0;
		req = '0;
		void'($urandom(52125));
		boot(1'b0, 1'b0);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h202});
		rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h1});
		rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h0});
		rd(5'h10, {RESP_SLVERR, 32'h0});
		wr(5'h14, 32'h1, RESP_SLVERR);
		r = $urandom;
		wr(ADDR_IRQ_MASK, r, RESP_OKAY);
		rd(ADDR_IRQ_MASK, {RESP_OKAY, 27'h0, r[4:0]});
		wr(ADDR_CTRL, r, RESP_OKAY);
		rd(ADDR_CTRL, {RESP_OKAY, 31'h0, r[0]});
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_IRQ_MASK, 32'h4, RESP_OKAY);
		btn(1'b1, 1'b0, 25);
		chb(motor, 1'b1);
		chb(irq, 1'b1);
		w(int'($urandom % 32));
		chb(motor, 1'b1);
		rd(ADDR_IRQ_STATUS, {RESP_OKAY, 32'h4});
		w(1);
		chb(irq, 1'b0);
		btn(1'b0, 1'b0, 25);
		chb(motor, 1'b0);
		@(posedge clk) paper_end <= 1'b1;
		btn(1'b1, 1'b0, 25);
		chb(motor, 1'b0);
		chb(l_pe, 1'b1);
		@(posedge clk) paper_end <= 1'b0;
		head_open <= 1'b1;
		w(5);
		chb(motor, 1'b0);
		chb(l_pe, 1'b1);
		@(posedge clk) head_open <= 1'b0;
		w(5);
		chb(l_pe, 1'b0);
		chb(motor, 1'b1);
		btn(1'b0, 1'b0, 25);
		btn(1'b0, 1'b1, 25);
		btn(1'b1, 1'b1, 30);
		btn(1'b0, 1'b0, 25);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h202});
		chk(34'(yes_n + no_n), 34'h0);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		btn(1'b1, 1'b0, 16);
		chb(motor, 1'b1);
		w(25);
		chb(motor, 1'b0);
		btn(1'b0, 1'b0, 5);
		@(posedge clk) error_in <= 1'b1;
		w(3);
		chb(l_err, 1'b1);
		@(posedge clk) error_in <= 1'b0;
		power_good <= 1'b0;
		w(5);
		chb(l_err, 1'b0);
		chb(l_pwr, 1'b0);
		@(posedge clk) power_good <= 1'b1;
		w(5);
		chb(l_pwr, 1'b1);
		$display("test normal done");
		boot(1'b0, 1'b1);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h280});
		btn(1'b0, 1'b0, 25);
		y0 = yes_n;
		n0 = no_n;
		btn(1'b1, 1'b0, 25);
		btn(1'b0, 1'b0, 25);
		chk(34'(yes_n - y0), 34'h1);
		chk(34'(no_n - n0), 34'h0);
		btn(1'b0, 1'b1, 25);
		btn(1'b0, 1'b0, 25);
		chk(34'(no_n - n0), 34'h1);
		chk(34'(yes_n - y0), 34'h1);
		$display("test config done");
		boot(1'b1, 1'b1);
		chb(hex, 1'b1);
		rd(ADDR_STATUS, {RESP_OKAY, 32'h300});
		btn(1'b0, 1'b0, 5);
		$display("test hex done");
		boot(1'b1, 1'b0);
		chb(report, 1'b1);
		chb(sample, 1'b0);
		w(40);
		chb(report, 1'b0);
		chb(sample, 1'b1);
		chk(34'(cut_n), 34'h0);
		btn(1'b0, 1'b0, 40);
		chb(sample, 1'b0);
		chk(34'(cut_n), 34'h1);
		$display("test self-test done");
		finish_test();
	end
endmodule

//--- verilog/ppmc_debounce.sv
// two-flop synchroniser followed by a stability counter for one pin
// assumes the pin is asynchronous to clock_i; output is the settled level

`timescale 1ns/1ps

module ppmc_debounce
	import ppmc_pkg::*;
#(
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic level;
		logic [CNT_W-1:0] cnt;
	} ppmc_db_t;

	ppmc_db_t r;
	ppmc_db_t next_r;

	always_comb begin
		next_r = r;
		next_r.s1 = pin_i;
		next_r.s2 = r.s1;
		// any bounce restarts the window
		if (r.s2 == r.level) begin
			next_r.cnt = '0;
		end else if (r.cnt == CNT_W'(STABLE_CYCLES - 1)) begin
			next_r.level = r.s2;
			next_r.cnt = '0;
		end else begin
			next_r.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level_o = r.level;

endmodule

//--- verilog/ppmc_pkg.sv
// package of the printer front-panel mode control block
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus

package ppmc_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int DEBOUNCE_MS = 5;
	localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
	// buttons get two debounce windows to settle before the mode is sampled
	localparam int STARTUP_CYCLES = 2 * DEBOUNCE_CYCLES;
	localparam int CNT_W = 20;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ctrl fields and reset values
	localparam int CTRL_MARK_BIT = 0;
	localparam logic CTRL_MARK_RESET = 1'b0;

	// interrupt event bits
	localparam int IRQ_W = 5;
	localparam int IRQ_MODE = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_FEED = 2;
	localparam int IRQ_MARK = 3;
	localparam int IRQ_CUT = 4;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

	// synchronised sensor vector positions
	localparam int SNS_W = 4;
	localparam int SNS_PAPER = 0;
	localparam int SNS_HEAD = 1;
	localparam int SNS_MARK = 2;
	localparam int SNS_PWR = 3;

	// status register field positions
	localparam int STAT_LAMP_LSB = 9;
	localparam int STAT_FAULT_BIT = 12;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [8:0] {
		ST_BOOT = 9'h001,
		ST_NORMAL = 9'h002,
		ST_MARK = 9'h004,
		ST_REPORT = 9'h008,
		ST_SAMPLE = 9'h010,
		ST_CUT = 9'h020,
		ST_DONE = 9'h040,
		ST_CONFIG = 9'h080,
		ST_HEX = 9'h100
	} ppmc_state_t;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} ppmc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ppmc_axi_rsp_t;

endpackage

//--- verilog/ppmc_top.sv
// front-panel control: button debounce, power-up mode choice, paper feed,
// self-test sequencing, lamps, interrupt and an AXI4-Lite register slave
// assumes active-low button pins, active-high sensor pins, and that
// error_i, report_done_i and engine_busy_i come from logic on clock_i
// Notes on behaviour
// - feed only at power-up: self-test
// - feed plus setup at power-up: hex dump
// - setup only at power-up: configuration
// - configuration: feed is yes, setup is no
// - no mark sensor: feed while held
// - mark sensor: one press feeds one mark
// - feed ignored at paper end or head open
// - setup does nothing after normal start-up
// - green lamp follows power good
// - paper-out lamp on paper end or head open
// - printing halts on paper end or head open
// - error lamp on while error active
// - mode chosen only from power-up buttons
// - self-test first prints status report
// - sample text repeats while feed held
// - feed release stops printing, then one cut
// - hex dump prints bytes, runs no commands

`timescale 1ns/1ps

module ppmc_top
	import ppmc_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
	parameter int STARTUP_LEN = STARTUP_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic feed_button_n_i,
	input wire logic setup_button_n_i,
	input wire logic paper_end_i,
	input wire logic head_open_i,
	input wire logic mark_detect_i,
	input wire logic power_good_i,
	input wire logic error_i,
	input wire logic report_done_i,
	input wire logic engine_busy_i,
	input wire ppmc_axi_req_t axi_i,
	output ppmc_axi_rsp_t axi_o,
	output logic feed_motor_o,
	output logic print_report_o,
	output logic print_sample_o,
	output logic cut_o,
	output logic cfg_yes_o,
	output logic cfg_no_o,
	output logic hex_dump_o,
	output logic lamp_power_o,
	output logic lamp_paper_out_o,
	output logic lamp_error_o,
	output logic irq_o
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		ppmc_state_t state;
		logic [CNT_W-1:0] boot_cnt;
		logic [SNS_W-1:0] sns_s1;
		logic [SNS_W-1:0] sns_s2;
		logic feed_q;
		logic setup_q;
		logic mark_q;
		logic fault_q;
		logic motor;
		logic report;
		logic sample;
		logic cut;
		logic yes;
		logic no;
		logic lamp_pwr;
		logic lamp_pe;
		logic lamp_err;
		logic mark_en;
		logic [IRQ_W-1:0] irq;
		logic [IRQ_W-1:0] irq_mask;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ppmc_core_t;

	ppmc_core_t r, next_r;
	logic [1:0] btn;
	logic feed, setup, fault, mark, boot_end;
	logic feed_rise, setup_rise, mark_rise;
	logic [IRQ_W-1:0] ev, clr;
	logic [31:0] status_word;

	// ************************************************************
	// button debounce
	// ************************************************************
	// pins are inverted ahead of the synchroniser so pressed reads high
	for (genvar i = 0; i < 2; i++) begin : g_btn
		ppmc_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_db (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.pin_i(i == 0 ? ~feed_button_n_i : ~setup_button_n_i),
			.level_o(btn[i])
		);
	end

	assign feed = btn[0];
	assign setup = btn[1];
	assign fault = r.sns_s2[SNS_PAPER] | r.sns_s2[SNS_HEAD];
	assign mark = r.sns_s2[SNS_MARK];
	assign feed_rise = feed & ~r.feed_q;
	assign setup_rise = setup & ~r.setup_q;
	assign mark_rise = mark & ~r.mark_q;
	assign boot_end = r.state == ST_BOOT && r.boot_cnt == CNT_W'(STARTUP_LEN - 1);
	always_comb begin
		status_word = '0;
		status_word[8:0] = r.state;
		status_word[STAT_LAMP_LSB +: 3] = {r.lamp_err, r.lamp_pe, r.lamp_pwr};
		status_word[STAT_FAULT_BIT] = fault;
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_r = r;
		ev = '0;
		clr = '0;
		next_r.sns_s1 = {power_good_i, mark_detect_i, head_open_i, paper_end_i};
		next_r.sns_s2 = r.sns_s1;
		next_r.feed_q = feed;
		next_r.setup_q = setup;
		next_r.mark_q = mark;
		next_r.fault_q = fault;
		next_r.cut = 1'b0;
		next_r.yes = 1'b0;
		next_r.no = 1'b0;
		ev[IRQ_FAULT] = fault & ~r.fault_q;
		// buttons only steer the mode here, so late presses never select one
		unique case (r.state)
			ST_BOOT: begin
				if (boot_end) begin
					ev[IRQ_MODE] = 1'b1;
					if (feed && setup) begin
						next_r.state = ST_HEX;
					end else if (feed) begin
						next_r.state = ST_REPORT;
					end else if (setup) begin
						next_r.state = ST_CONFIG;
					end else begin
						next_r.state = ST_NORMAL;
					end
				end else begin
					next_r.boot_cnt = r.boot_cnt + 1'b1;
				end
			end
			// setup is not looked at in normal operation
			ST_NORMAL: begin
				ev[IRQ_FEED] = feed_rise & ~fault;
				if (feed_rise && r.mark_en && !fault) begin
					next_r.state = ST_MARK;
				end
			end
			ST_MARK: begin
				// stops on the next mark edge, leaving the current one behind
				if (fault || mark_rise) begin
					next_r.state = ST_NORMAL;
					ev[IRQ_MARK] = mark_rise;
				end
			end
			ST_REPORT: if (report_done_i) next_r.state = ST_SAMPLE;
			ST_SAMPLE: if (!feed) next_r.state = ST_CUT;
			ST_CUT: begin
				// wait for the engine to drain the last line before cutting
				if (!engine_busy_i) begin
					next_r.cut = 1'b1;
					next_r.state = ST_DONE;
					ev[IRQ_CUT] = 1'b1;
				end
			end
			ST_CONFIG: begin
				next_r.yes = feed_rise;
				next_r.no = setup_rise;
			end
			ST_DONE, ST_HEX: next_r.state = r.state;
			default: next_r.state = ST_BOOT;
		endcase
		next_r.motor = !fault && ((r.state == ST_NORMAL && feed && !r.mark_en)
			|| next_r.state == ST_MARK);
		next_r.report = !fault && next_r.state == ST_REPORT;
		next_r.sample = !fault && next_r.state == ST_SAMPLE;
		next_r.lamp_pwr = r.sns_s2[SNS_PWR];
		next_r.lamp_pe = fault;
		next_r.lamp_err = error_i;
		// ********************************************************
		// AXI4-Lite write path
		// ********************************************************
		if (axi_i.awvalid && !r.aw_got && !r.bvalid) begin
			next_r.aw_got = 1'b1;
			next_r.awaddr = axi_i.awaddr;
		end
		if (axi_i.wvalid && !r.w_got && !r.bvalid) begin
			next_r.w_got = 1'b1;
			next_r.wdata = axi_i.wdata;
			next_r.wstrb = axi_i.wstrb;
		end
		if (r.aw_got && r.w_got) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case ({r.awaddr[ADDR_W-1:2], 2'b00})
				ADDR_CTRL: if (r.wstrb[0]) next_r.mark_en = r.wdata[CTRL_MARK_BIT];
				ADDR_IRQ_MASK: if (r.wstrb[0]) next_r.irq_mask = r.wdata[IRQ_W-1:0];
				ADDR_STATUS, ADDR_IRQ_STATUS: next_r.bresp = RESP_OKAY;
				default: next_r.bresp = RESP_SLVERR;
			endcase
		end
		if (r.bvalid && axi_i.bready) next_r.bvalid = 1'b0;
		// ********************************************************
		// AXI4-Lite read path
		// ********************************************************
		if (r.rvalid && axi_i.rready) next_r.rvalid = 1'b0;
		if (axi_i.arvalid && !r.rvalid) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			next_r.rdata = '0;
			unique case ({axi_i.araddr[ADDR_W-1:2], 2'b00})
				ADDR_CTRL: next_r.rdata[CTRL_MARK_BIT] = r.mark_en;
				ADDR_STATUS: next_r.rdata = status_word;
				ADDR_IRQ_STATUS: begin
					next_r.rdata[IRQ_W-1:0] = r.irq;
					clr = r.irq;
				end
				ADDR_IRQ_MASK: next_r.rdata[IRQ_W-1:0] = r.irq_mask;
				default: next_r.rresp = RESP_SLVERR;
			endcase
		end

		// an event in the clearing cycle survives the read
		next_r.irq = (r.irq & ~clr) | ev;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.state <= ST_BOOT;
			r.mark_en <= CTRL_MARK_RESET;
			r.irq_mask <= IRQ_MASK_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign axi_o.awready = !r.aw_got && !r.bvalid;
	assign axi_o.wready = !r.w_got && !r.bvalid;
	assign axi_o.bvalid = r.bvalid;
	assign axi_o.bresp = r.bresp;
	assign axi_o.arready = !r.rvalid;
	assign axi_o.rvalid = r.rvalid;
	assign axi_o.rdata = r.rdata;
	assign axi_o.rresp = r.rresp;
	assign feed_motor_o = r.motor;
	assign print_report_o = r.report;
	assign print_sample_o = r.sample;
	assign cut_o = r.cut;
	assign cfg_yes_o = r.yes;
	assign cfg_no_o = r.no;
	// the data path prints raw bytes as hex and skips command decode
	assign hex_dump_o = r.state == ST_HEX;
	assign lamp_power_o = r.lamp_pwr;
	assign lamp_paper_out_o = r.lamp_pe;
	assign lamp_error_o = r.lamp_err;
	assign irq_o = |(r.irq & r.irq_mask);

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_boot_both;
		boot_end && feed && setup;
	endsequence
	sequence s_release;
		r.state == ST_SAMPLE && !feed;
	endsequence
	sequence s_cut_go;
		r.state == ST_CUT && !engine_busy_i;
	endsequence

	property p_boot_test;
		boot_end && feed && !setup |=> r.state == ST_REPORT ##1 r.state != ST_BOOT;
	endproperty
	a_boot_test: assert property (p_boot_test) else $error("self-test not entered");
	property p_boot_hex;
		s_boot_both |=> hex_dump_o [*3];
	endproperty
	a_boot_hex: assert property (p_boot_hex) else $error("hex dump not entered");
	property p_boot_cfg;
		boot_end && setup && !feed |=> r.state == ST_CONFIG;
	endproperty
	a_boot_cfg: assert property (p_boot_cfg) else $error("configuration not entered");
	property p_cfg_answer;
		r.state == ST_CONFIG && feed_rise && !setup_rise |=> cfg_yes_o && !cfg_no_o ##1 !cfg_yes_o;
	endproperty
	a_cfg_answer: assert property (p_cfg_answer) else $error("yes answer missing");
	property p_cont_feed;
		r.state == ST_NORMAL && feed && !r.mark_en && !fault |=> feed_motor_o;
	endproperty
	a_cont_feed: assert property (p_cont_feed) else $error("continuous feed missing");
	// a fresh press right after the mark may restart the motor, so only the stop cycle counts
	property p_mark_stop;
		r.state == ST_MARK && mark_rise |=> r.state == ST_NORMAL && !feed_motor_o;
	endproperty
	a_mark_stop: assert property (p_mark_stop) else $error("mark feed did not stop");
	property p_fault_block;
		fault |=> !feed_motor_o && !print_sample_o && !print_report_o;
	endproperty
	a_fault_block: assert property (p_fault_block) else $error("motion during fault");
	property p_setup_ignored;
		r.state == ST_NORMAL && setup_rise && !feed_rise |=> r.state == ST_NORMAL;
	endproperty
	a_setup_ignored: assert property (p_setup_ignored) else $error("setup had effect");
	property p_pwr_lamp;
		$rose(r.sns_s2[SNS_PWR]) |=> lamp_power_o;
	endproperty
	a_pwr_lamp: assert property (p_pwr_lamp) else $error("power lamp late");
	property p_pe_lamp;
		lamp_paper_out_o == $past(fault);
	endproperty
	a_pe_lamp: assert property (p_pe_lamp) else $error("paper-out lamp wrong");
	property p_err_lamp;
		error_i |=> lamp_error_o;
	endproperty
	a_err_lamp: assert property (p_err_lamp) else $error("error lamp off");
	property p_no_late_mode;
		r.state == ST_NORMAL |=> !(r.state inside {ST_REPORT, ST_CONFIG, ST_HEX});
	endproperty
	a_no_late_mode: assert property (p_no_late_mode) else $error("late special mode");
	property p_sample_hold;
		r.state == ST_SAMPLE && feed && !fault |=> print_sample_o;
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("sample print stopped");
	property p_release_cut;
		s_release |=> !print_sample_o ##0 r.state == ST_CUT;
	endproperty
	a_release_cut: assert property (p_release_cut) else $error("release not honoured");
	property p_cut_once;
		s_cut_go |=> cut_o ##1 !cut_o [*2];
	endproperty
	a_cut_once: assert property (p_cut_once) else $error("cut pulse wrong");

endmodule
